// [bench/evt_pin_partner.sv]
// pin partner: external pulse source and observer of the shared timer pin
`default_nettype none
module evt_pin_partner (
    // clock
    input  wire logic  clk,
    // timer side of the pin
    input  wire logic  pin_oe,
    input  wire logic  pin_out,
    // resolved pin level
    output logic       pin_wire
);
    timeunit 1ns;
    timeprecision 1ns;

    logic drv_r;

    initial drv_r = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // the partner drives only while the timer keeps its output buffer off
    assign pin_wire = pin_oe ? pin_out : drv_r;

    task automatic set_level(input logic lvl);
        @(posedge clk);
        drv_r <= lvl;
    endtask : set_level

    // cycles at the given level over one full pwm period of 256 count clocks
    task automatic count_level(input logic lvl, output int cnt);
        cnt = 0;
        repeat (256) begin
            @(negedge clk);
            if (pin_wire === lvl) cnt++;
        end
    endtask : count_level
endmodule : evt_pin_partner
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the event timer against pin partner and bench model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk_sys;
    logic       nrst;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    wire logic  pin_w;
    logic       pin_out;
    logic       pin_oe;
    logic       match_req;
    int         err_total;
    int         samples_checked;
    int         seed;
    int         g;
    int         n;
    logic [7:0] cmp_list [3];
    // bench model: expected event spacing, one entry per compare value
    int         exp_q [$];

    evt_timer dut (
        .CLK_SYS                 (clk_sys),
        .NRST                    (nrst),
        .ADDR                    (addr),
        .WDATA                   (wdata),
        .WR                      (wr),
        .RD                      (rd),
        .RDATA                   (rdata),
        .EVENT_INPUT_PIN         (pin_w),
        .WAVE_OUTPUT_PIN         (pin_out),
        .WAVE_OUTPUT_PIN_OE      (pin_oe),
        .MATCH_INTERRUPT_REQUEST (match_req)
    );

    evt_pin_partner pin (
        .clk      (clk_sys),
        .pin_oe   (pin_oe),
        .pin_out  (pin_out),
        .pin_wire (pin_w)
    );

    initial clk_sys = 1'b0;
    always #25 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask : rd_reg

    // cycles between the first two events: request pulses or pin toggles
    task automatic gap(input bit on_pin, output int gp);
        int   c;
        int   seen;
        logic p;
        logic e;
        c    = 0;
        seen = 0;
        gp   = -1;
        p    = pin_w;
        repeat (600) begin
            @(negedge clk_sys);
            c++;
            e = on_pin ? (pin_w !== p) : (match_req === 1'b1);
            p = pin_w;
            if (e) begin
                if (seen == 1 && gp < 0) gp = c;
                seen++;
                c = 0;
            end
        end
    endtask : gap

    task automatic final_report;
        $display("errors %0d comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        seed            = 52;
        err_total       = 0;
        samples_checked = 0;
        nrst            = 1'b0;
        addr            = 3'h0;
        wdata           = 8'h00;
        wr              = 1'b0;
        rd              = 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        // reset contents, unmapped addresses read zero
        for (n = 0; n < 7; n++) rd_reg(n[2:0], (n == 4) ? 8'h02 : 8'h00);
        // stopped timer still shows the flop level on the pin while mode bit 0 is set, low when it is clear
        wr_reg(3'h4, 8'h00);
        wr_reg(3'h2, 8'h0B);
        rd_reg(3'h2, 8'h03);
        repeat (4) @(posedge clk_sys);
        check({15'h0000, pin_w}, 16'h0001);
        wr_reg(3'h2, 8'h07);
        repeat (4) @(posedge clk_sys);
        check({15'h0000, pin_w}, 16'h0000);
        wr_reg(3'h2, 8'h0A);
        repeat (4) @(posedge clk_sys);
        check({15'h0000, pin_w}, 16'h0000);
        // event counting on each edge kind, pin left at the new level
        wr_reg(3'h4, 8'h02);
        for (n = 0; n < 2; n++) begin
            wr_reg(3'h2, 8'h00);
            wr_reg(3'h1, n[7:0]);
            wr_reg(3'h0, 8'h05);
            wr_reg(3'h2, 8'h80);
            pin.set_level(1'b1);
            repeat (8) @(posedge clk_sys);
            rd_reg(3'h3, n[7:0]);
            pin.set_level(1'b0);
            repeat (8) @(posedge clk_sys);
            rd_reg(3'h3, 8'h01);
        end
        wr_reg(3'h2, 8'h00);
        repeat (2) @(posedge clk_sys);
        rd_reg(3'h3, 8'h00);
        // interval and square wave at compare boundaries and one random value
        cmp_list[0] = 8'h00;
        cmp_list[1] = 8'h01 + 8'($unsigned($random(seed)) % 6);
        cmp_list[2] = 8'hFF;
        wr_reg(3'h4, 8'h00);
        foreach (cmp_list[i]) begin
            wr_reg(3'h2, 8'h00);
            wr_reg(3'h1, 8'h02);
            wr_reg(3'h0, cmp_list[i]);
            wr_reg(3'h2, 8'h8B);
            exp_q.push_back(int'(cmp_list[i]) + 1);
            gap(1'b0, g);
            check(16'(g), 16'(exp_q[0]));
            gap(1'b1, g);
            check(16'(g), 16'(exp_q.pop_front()));
        end
        // pwm in both polarities, duty, buffered compare and stop
        for (n = 0; n < 2; n++) begin
            foreach (cmp_list[i]) begin
                wr_reg(3'h2, 8'h00);
                wr_reg(3'h0, cmp_list[i]);
                wr_reg(3'h2, 8'h41 + 8'(2 * n));
                repeat (4) @(posedge clk_sys);
                check({15'h0000, pin_w}, 16'(n));
                wr_reg(3'h2, 8'hC1 + 8'(2 * n));
                repeat (300) @(posedge clk_sys);
                pin.count_level(~n[0], g);
                check(16'(g), {8'h00, cmp_list[i]});
                wr_reg(3'h0, cmp_list[2 - i]);
                rd_reg(3'h0, cmp_list[2 - i]);
                repeat (600) @(posedge clk_sys);
                pin.count_level(~n[0], g);
                check(16'(g), {8'h00, cmp_list[2 - i]});
                wr_reg(3'h2, 8'h41 + 8'(2 * n));
                repeat (4) @(posedge clk_sys);
                check({15'h0000, pin_w}, 16'(n));
            end
        end
        final_report;
    end
endmodule : tb_top
`default_nettype wire

// [design/evt_pkg.sv]
// types shared by the event timer modules
`default_nettype none
package evt_pkg;

    typedef enum logic [2:0] {
        CS_EVT_FALL = 3'b000,
        CS_EVT_RISE = 3'b001,
        CS_DIV1     = 3'b010,
        CS_DIV2     = 3'b011,
        CS_DIV4     = 3'b100,
        CS_DIV64    = 3'b101,
        CS_DIV256   = 3'b110,
        CS_DIV8192  = 3'b111
    } evt_csel_type;

endpackage : evt_pkg
`default_nettype wire

// [design/evt_prescaler.sv]
// count clock source: free prescaler or synchronised event edges
`include "evt_timer_regs.svh"
`default_nettype none
module evt_prescaler
    import evt_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // selection and event edges
    input  wire evt_csel_type csel,
    input  wire logic         ev_rise,
    input  wire logic         ev_fall,
    // count clock pulse
    output logic              tick
);

    logic [`EVT_DIV_W-1:0] div_r;

    // free running, so a start lands anywhere within a count period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + `EVT_DIV_ONE;
        end
    end

    always_comb begin
        unique case (csel)
            CS_EVT_FALL: tick = ev_fall;
            CS_EVT_RISE: tick = ev_rise;
            CS_DIV1:     tick = 1'b1;
            CS_DIV2:     tick = &(div_r | ~`EVT_DIV2_MASK);
            CS_DIV4:     tick = &(div_r | ~`EVT_DIV4_MASK);
            CS_DIV64:    tick = &(div_r | ~`EVT_DIV64_MASK);
            CS_DIV256:   tick = &(div_r | ~`EVT_DIV256_MASK);
            CS_DIV8192:  tick = &(div_r | ~`EVT_DIV8192_MASK);
        endcase
    end

endmodule : evt_prescaler
`default_nettype wire

// [design/evt_timer.sv]
// 8-bit event timer with interval, event count, square wave and pwm operation
//
// Contract
// - event counting steps the counter on the chosen pin edge, 00H falling, 01H rising
// - clear-and-start: on match clear counter, keep counting, raise match request
// - square wave: each match inverts output flop, clears counter, raises request
// - square frequency is one over two times count period times compare plus one
// - output flop start level loaded from preset and preclear bits 3 and 2
// - mode bit 6 set selects free running pwm
// - pwm polarity bit 1: zero active high, one active low
// - clock select bits 0 to 2 pick count clock; mode bit 0 gates output
// - pwm inactive until overflow, active at overflow, inactive at compare match
// - clearing run bit in pwm stops counting and forces inactive output
// - pwm period 256 count clocks, active width equals compare value
// - pwm compare transfers at next overflow, or second if written at FFH
// - compare read returns newly written value before transfer
// - first match after start may come up to one count clock early
// - writing run bit zero clears and stops counter; one starts counting
// - preset and preclear bits are write only and read zero
// - mode settings show on the output pin whether running or not
`include "evt_timer_regs.svh"
`default_nettype none
module evt_timer
    import evt_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    // register port
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // shared timer pin
    input  wire logic        EVENT_INPUT_PIN,
    output logic             WAVE_OUTPUT_PIN,
    output logic             WAVE_OUTPUT_PIN_OE,
    // match request
    output logic             MATCH_INTERRUPT_REQUEST
);

    function automatic logic addr_hit(input logic [2:0] a, input logic [2:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]   event_up_counter_r;
    logic [7:0]   match_compare_reg_r;
    logic [7:0]   cmp_act_r;
    evt_csel_type count_clock_select_reg_r;
    logic         count_run_bit_r;
    logic         pwm_mode_bit_r;
    logic         toggle_or_polarity_bit_r;
    logic         pin_drive_enable_bit_r;
    logic         pin_direction_bit_r;
    logic         pin_output_latch_r;
    logic         out_flop_r;
    logic         pwm_act_r;
    logic         pend_r;
    logic         armed_r;
    logic [7:0]   rdata_r;
    logic         irq_r;
    logic         pin_out_r;
    logic         pin_oe_r;
    logic         ev_meta_r;
    logic         ev_sync_r;
    logic         ev_prev_r;

    logic         tick;
    logic         ev_rise;
    logic         ev_fall;
    logic         wr_cmp;
    logic         wr_csel;
    logic         wr_mode;
    logic         wr_port;
    logic         step;
    logic         match;
    logic         ovf;
    logic [7:0]   cnt_inc;
    logic [7:0]   cmp_use;
    logic         pwm_hit;
    logic         wave_nxt;
    logic [7:0]   rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser and count clock

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ev_meta_r <= 1'b0;
            ev_sync_r <= 1'b0;
            ev_prev_r <= 1'b0;
        end else begin
            ev_meta_r <= EVENT_INPUT_PIN;
            ev_sync_r <= ev_meta_r;
            ev_prev_r <= ev_sync_r;
        end
    end

    assign ev_rise = ev_sync_r & ~ev_prev_r;
    assign ev_fall = ~ev_sync_r & ev_prev_r;

    evt_prescaler u_prescaler (
        .clk     (CLK_SYS),
        .nrst    (NRST),
        .csel    (count_clock_select_reg_r),
        .ev_rise (ev_rise),
        .ev_fall (ev_fall),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    assign wr_cmp  = WR && addr_hit(ADDR, `EVT_ADDR_CMP);
    assign wr_csel = WR && addr_hit(ADDR, `EVT_ADDR_CSEL);
    assign wr_mode = WR && addr_hit(ADDR, `EVT_ADDR_MODE);
    assign wr_port = WR && addr_hit(ADDR, `EVT_ADDR_PORT);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            count_clock_select_reg_r <= CS_EVT_FALL;
            count_run_bit_r          <= 1'b0;
            pwm_mode_bit_r           <= 1'b0;
            toggle_or_polarity_bit_r <= 1'b0;
            pin_drive_enable_bit_r   <= 1'b0;
            pin_direction_bit_r      <= `EVT_RST_DIR;
            pin_output_latch_r       <= 1'b0;
        end else begin
            if (wr_csel) begin
                count_clock_select_reg_r <= evt_csel_type'(WDATA[2:0]);
            end
            if (wr_mode) begin
                count_run_bit_r          <= WDATA[`EVT_MODE_RUN];
                pwm_mode_bit_r           <= WDATA[`EVT_MODE_PWM];
                toggle_or_polarity_bit_r <= WDATA[`EVT_MODE_TOG];
                pin_drive_enable_bit_r   <= WDATA[`EVT_MODE_TOE];
            end
            if (wr_port) begin
                pin_direction_bit_r <= WDATA[`EVT_PORT_DIR];
                pin_output_latch_r  <= WDATA[`EVT_PORT_LATCH];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter

    assign step    = count_run_bit_r && tick;
    assign match   = (event_up_counter_r == cmp_act_r);
    assign ovf     = (event_up_counter_r == `EVT_CNT_MAX);
    assign cnt_inc = event_up_counter_r + `EVT_CNT_ONE;
    assign cmp_use = (ovf && armed_r) ? match_compare_reg_r : cmp_act_r;
    assign pwm_hit = (cnt_inc == cmp_use);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            event_up_counter_r <= `EVT_CNT_ZERO;
        end else if ((wr_mode && !WDATA[`EVT_MODE_RUN]) || !count_run_bit_r) begin
            event_up_counter_r <= `EVT_CNT_ZERO;
        end else if (step) begin
            if (!pwm_mode_bit_r && match) begin
                event_up_counter_r <= `EVT_CNT_ZERO;
            end else begin
                event_up_counter_r <= cnt_inc;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= step && (pwm_mode_bit_r ? pwm_hit : match);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare buffer and transfer

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            match_compare_reg_r <= `EVT_RST_BYTE;
        end else if (wr_cmp) begin
            match_compare_reg_r <= WDATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pend_r  <= 1'b0;
            armed_r <= 1'b0;
        end else if (!pwm_mode_bit_r || !count_run_bit_r) begin
            pend_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            if (wr_cmp) begin
                pend_r <= 1'b1;
            end else if (step && cnt_inc == `EVT_CNT_MAX) begin
                pend_r <= 1'b0;
            end
            if (step && cnt_inc == `EVT_CNT_MAX) begin
                armed_r <= pend_r;
            end else if (step && ovf) begin
                armed_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cmp_act_r <= `EVT_RST_BYTE;
        end else if (!pwm_mode_bit_r || !count_run_bit_r) begin
            cmp_act_r <= match_compare_reg_r;
        end else if (step && ovf && armed_r) begin
            cmp_act_r <= match_compare_reg_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output flop and pwm level

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            out_flop_r <= 1'b0;
        end else if (wr_mode && !WDATA[`EVT_MODE_PWM] && WDATA[`EVT_MODE_PRESET] && !WDATA[`EVT_MODE_PRECLR]) begin
            out_flop_r <= 1'b1;
        end else if (wr_mode && !WDATA[`EVT_MODE_PWM] && !WDATA[`EVT_MODE_PRESET] && WDATA[`EVT_MODE_PRECLR]) begin
            out_flop_r <= 1'b0;
        end else if (step && !pwm_mode_bit_r && match && toggle_or_polarity_bit_r) begin
            out_flop_r <= ~out_flop_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pwm_act_r <= 1'b0;
        end else if (!count_run_bit_r || !pwm_mode_bit_r) begin
            pwm_act_r <= 1'b0;
        end else if (step) begin
            if (pwm_hit) begin
                pwm_act_r <= 1'b0;
            end else if (ovf) begin
                pwm_act_r <= 1'b1;
            end
        end
    end

    always_comb begin
        if (pwm_mode_bit_r) begin
            wave_nxt = pin_drive_enable_bit_r & (pwm_act_r ^ toggle_or_polarity_bit_r);
        end else begin
            wave_nxt = pin_drive_enable_bit_r & out_flop_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
        end else begin
            pin_out_r <= wave_nxt | pin_output_latch_r;
            pin_oe_r  <= ~pin_direction_bit_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    always_comb begin
        rdata_nxt = `EVT_RST_BYTE;
        if (addr_hit(ADDR, `EVT_ADDR_CMP)) begin
            rdata_nxt = match_compare_reg_r;
        end else if (addr_hit(ADDR, `EVT_ADDR_CSEL)) begin
            rdata_nxt = {5'h00, count_clock_select_reg_r};
        end else if (addr_hit(ADDR, `EVT_ADDR_MODE)) begin
            rdata_nxt = {count_run_bit_r, pwm_mode_bit_r, 4'h0, toggle_or_polarity_bit_r,
                         pin_drive_enable_bit_r};
        end else if (addr_hit(ADDR, `EVT_ADDR_CNT)) begin
            rdata_nxt = event_up_counter_r;
        end else if (addr_hit(ADDR, `EVT_ADDR_PORT)) begin
            rdata_nxt = {6'h00, pin_direction_bit_r, pin_output_latch_r};
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rdata_r <= `EVT_RST_BYTE;
        end else if (RD) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= `EVT_RST_BYTE;
        end
    end

    assign RDATA                   = rdata_r;
    assign WAVE_OUTPUT_PIN         = pin_out_r;
    assign WAVE_OUTPUT_PIN_OE      = pin_oe_r;
    assign MATCH_INTERRUPT_REQUEST = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    sequence s_clear_step;
        step && !pwm_mode_bit_r && match && !wr_mode;
    endsequence

    sequence s_pwm_overflow;
        step && pwm_mode_bit_r && ovf && !wr_mode;
    endsequence

    property p_clear_on_match;
        s_clear_step |=> (event_up_counter_r == `EVT_CNT_ZERO) && MATCH_INTERRUPT_REQUEST;
    endproperty
    a_clear_on_match: assert property (p_clear_on_match) else $error("no clear or request on match");

    property p_edge_count;
        count_run_bit_r && !wr_mode && !wr_csel && count_clock_select_reg_r == CS_EVT_RISE && ev_rise
            && !match |=> event_up_counter_r == $past(event_up_counter_r) + `EVT_CNT_ONE;
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("rising edge not counted");

    property p_square_toggle;
        s_clear_step ##0 toggle_or_polarity_bit_r |=> out_flop_r != $past(out_flop_r);
    endproperty
    a_square_toggle: assert property (p_square_toggle) else $error("output flop not inverted");

    property p_preset;
        wr_mode && !WDATA[`EVT_MODE_PWM] && WDATA[`EVT_MODE_PRESET] && !WDATA[`EVT_MODE_PRECLR]
            |=> out_flop_r ##1 (pin_out_r == (pin_drive_enable_bit_r | pin_output_latch_r));
    endproperty
    a_preset: assert property (p_preset) else $error("preset level not loaded");

    property p_pwm_active;
        s_pwm_overflow ##0 (cmp_use != `EVT_CNT_ZERO) |=> pwm_act_r ##1
            (pin_out_r == ((pin_drive_enable_bit_r & ~toggle_or_polarity_bit_r) | pin_output_latch_r));
    endproperty
    a_pwm_active: assert property (p_pwm_active) else $error("pwm not active after overflow");

    property p_pwm_inactive;
        step && pwm_mode_bit_r && pwm_hit |=> !pwm_act_r;
    endproperty
    a_pwm_inactive: assert property (p_pwm_inactive) else $error("pwm still active after match");

    property p_pwm_stop;
        wr_mode && pwm_mode_bit_r && !WDATA[`EVT_MODE_RUN] |=> ##1 !pwm_act_r && event_up_counter_r == `EVT_CNT_ZERO;
    endproperty
    a_pwm_stop: assert property (p_pwm_stop) else $error("pwm not stopped");

    property p_transfer;
        s_pwm_overflow ##0 armed_r |=> cmp_act_r == $past(match_compare_reg_r);
    endproperty
    a_transfer: assert property (p_transfer) else $error("compare not transferred");

    property p_read_cmp;
        RD && addr_hit(ADDR, `EVT_ADDR_CMP) |=> RDATA == $past(match_compare_reg_r);
    endproperty
    a_read_cmp: assert property (p_read_cmp) else $error("compare read wrong");

    property p_read_mode;
        RD && addr_hit(ADDR, `EVT_ADDR_MODE) |=> RDATA[3:2] == 2'b00;
    endproperty
    a_read_mode: assert property (p_read_mode) else $error("write only bits read nonzero");

    property p_gate;
        !pin_drive_enable_bit_r && !pin_output_latch_r |=> !pin_out_r;
    endproperty
    a_gate: assert property (p_gate) else $error("output not gated");

    property p_level_stopped;
        !count_run_bit_r && !pwm_mode_bit_r && !wr_mode && pin_drive_enable_bit_r && !pin_output_latch_r
            |=> pin_out_r == $past(out_flop_r);
    endproperty
    a_level_stopped: assert property (p_level_stopped) else $error("stopped output wrong");

endmodule : evt_timer
`default_nettype wire

// [design/evt_timer_regs.svh]
// register map, field positions, reset values and counter constants of the event timer
`ifndef EVT_TIMER_REGS_SVH
`define EVT_TIMER_REGS_SVH

// register addresses
`define EVT_ADDR_CMP       3'h0
`define EVT_ADDR_CSEL      3'h1
`define EVT_ADDR_MODE      3'h2
`define EVT_ADDR_CNT       3'h3
`define EVT_ADDR_PORT      3'h4

// mode register fields
`define EVT_MODE_RUN       7
`define EVT_MODE_PWM       6
`define EVT_MODE_PRESET    3
`define EVT_MODE_PRECLR    2
`define EVT_MODE_TOG       1
`define EVT_MODE_TOE       0

// port register fields
`define EVT_PORT_DIR       1
`define EVT_PORT_LATCH     0

// reset values
`define EVT_RST_BYTE       8'h00
`define EVT_RST_CSEL       3'h0
`define EVT_RST_DIR        1'b1

// counter constants
`define EVT_CNT_ZERO       8'h00
`define EVT_CNT_ONE        8'h01
`define EVT_CNT_MAX        8'hFF

// prescaler masks: tick when the masked divider bits are all ones
`define EVT_DIV_W          13
`define EVT_DIV_ONE        13'h0001
`define EVT_DIV2_MASK      13'h0001
`define EVT_DIV4_MASK      13'h0003
`define EVT_DIV64_MASK     13'h003F
`define EVT_DIV256_MASK    13'h00FF
`define EVT_DIV8192_MASK   13'h1FFF

`endif
